// ===== verif/virtual_memory_translation_bench.sv
// Purpose: self-checking bench of the translation block
// Assumes: Avalon master waits for waitrequest low, bounded
// Notes:   entry 5 is the working entry throughout
`timescale 1ns/10ps
module virtual_memory_translation_bench;
    import vmt_pkg::*;
    logic clock = 0, reset_n = 0, avsRead = 0, avsWrite = 0, otherExc = 0;
    logic [5:0]  avsAddress = '0;
    logic [31:0] avsWritedata = '0, avsReaddata, q;
    logic        avsWaitrequest, kernelMode;
    vmt_req_t    xlateReq;
    vmt_rsp_t    xlateRsp;
    int          failures = 0, checked = 0;
    always #5 clock = ~clock;
    vmt_xlate vmt_xlate_inst (.clock(clock), .reset_n(reset_n),
        .avs_address(avsAddress), .avs_read(avsRead), .avs_write(avsWrite),
        .avs_writedata(avsWritedata), .avs_byteenable(4'hF),
        .avs_readdata(avsReaddata), .avs_waitrequest(avsWaitrequest),
        .xlateReq(xlateReq), .otherExcTaken(otherExc),
        .xlateRsp(xlateRsp), .kernelMode(kernelMode));
    vmt_pipe_model vmt_pipe_model_inst (.clock(clock), .req(xlateReq));
    task automatic end_of_test;
        $display("checks %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : end_of_test
    task automatic cmp(input logic [35:0] g, e, input string m);
        checked++;
        if (g !== e) begin
            failures++;
            $display("wrong value at %0t: %s", $time, m);
        end
    endtask : cmp
    // one Avalon access; request held until waitrequest seen low
    task automatic acc(input logic w, input logic [5:0] a,
                       input logic [31:0] d);
        int n = 0;
        @(posedge clock);
        avsRead <= !w;
        avsWrite <= w;
        avsAddress <= a;
        avsWritedata <= d;
        // sample waitrequest at each rising edge; data taken there too
        do @(posedge clock); while (avsWaitrequest !== 1'b0 && ++n < 20);
        if (n >= 20) begin
            failures++;
            end_of_test();
        end
        q = avsReaddata;
        avsRead <= 1'b0;
        avsWrite <= 1'b0;
    endtask : acc
    task automatic rd(input logic [5:0] a, input logic [31:0] e);
        acc(1'b0, a, 32'h0000_0000);
        cmp(q, e, "register read");
    endtask : rd
    task automatic tr(input logic [31:0] va, input logic w,
                      input logic [31:0] pa, input logic c, vmt_fault_t f);
        vmt_pipe_model_inst.issue(va, w);
        @(negedge clock);
        cmp(xlateRsp.fault, f, "fault code");
        if (f == FLT_NONE) cmp({xlateRsp.cached, xlateRsp.paddr}, {c, pa},
                               "translated address");
    endtask : tr
    initial begin
        repeat (10) @(posedge clock);
        reset_n <= 1'b1;
        rd(OFS_INDEX, 32'h0000_0000);
        rd(OFS_REV, REV_DFLT);
        acc(1'b1, OFS_REV, 32'h0000_0000);
        rd(OFS_REV, REV_DFLT);
        $display("test registers done");
        acc(1'b1, OFS_UPPER, 32'h1234_5A80);
        acc(1'b1, OFS_LOWER, 32'h00AB_C600);
        acc(1'b1, OFS_INDEX, 32'h0000_0500);
        acc(1'b1, OFS_OP, 32'h0000_0002);
        tr(32'h1234_5678, 1'b1, 32'h00AB_C678, 1'b1, FLT_NONE);
        acc(1'b1, OFS_UPPER, 32'h1234_5540);
        tr(32'h1234_5678, 1'b0, 32'h0, 1'b0, FLT_MISS);
        rd(OFS_FAULT, 32'h1234_5678);
        rd(OFS_CTX, 32'h0004_8D14);
        acc(1'b1, OFS_OP, 32'h0000_0004);
        rd(OFS_INDEX, 32'h8000_0500);
        acc(1'b1, OFS_UPPER, 32'h1234_5A80);
        acc(1'b1, OFS_OP, 32'h0000_0004);
        rd(OFS_INDEX, 32'h0000_0500);
        acc(1'b1, OFS_LOWER, 32'h0000_0000);
        acc(1'b1, OFS_OP, 32'h0000_0001);
        rd(OFS_LOWER, 32'h00AB_C600);
        $display("test entry operations done");
        acc(1'b1, OFS_LOWER, 32'h00AB_C200);
        acc(1'b1, OFS_OP, 32'h0000_0002);
        tr(32'h1234_5678, 1'b1, 32'h0, 1'b0, FLT_WPRT);
        // random victim first, so the indexed write below keeps entry 5
        acc(1'b1, OFS_UPPER, 32'hC000_7A80);
        acc(1'b1, OFS_LOWER, 32'h0000_9700);
        acc(1'b1, OFS_OP, 32'h0000_0003);
        acc(1'b1, OFS_UPPER, 32'h1234_5540);
        acc(1'b1, OFS_LOWER, 32'h00AB_CB00);
        acc(1'b1, OFS_OP, 32'h0000_0002);
        tr(32'h1234_5678, 1'b0, 32'h00AB_C678, 1'b0, FLT_NONE);
        tr(32'hC000_7010, 1'b1, 32'h0000_9010, 1'b1, FLT_NONE);
        tr(32'h8000_1234, 1'b0, 32'h0000_1234, 1'b1, FLT_NONE);
        tr(32'hA000_1234, 1'b0, 32'h0000_1234, 1'b0, FLT_NONE);
        $display("test translation done");
        acc(1'b1, OFS_MODE, 32'h0000_0001);
        tr(32'h8000_0000, 1'b0, 32'h0, 1'b0, FLT_ADDR);
        rd(OFS_FAULT, 32'h8000_0000);
        cmp(kernelMode, 1'b1, "mode after fault");
        acc(1'b1, OFS_MODE, 32'h0000_0002);
        acc(1'b1, OFS_OP, 32'h0000_0005);
        @(negedge clock);
        cmp(kernelMode, 1'b0, "mode after return");
        tr(32'h1234_5678, 1'b0, 32'h00AB_C678, 1'b0, FLT_NONE);
        @(posedge clock);
        otherExc <= 1'b1;
        @(posedge clock);
        otherExc <= 1'b0;
        @(negedge clock);
        cmp(kernelMode, 1'b1, "mode after exception");
        $display("test modes done");
        end_of_test();
    end
endmodule : virtual_memory_translation_bench

// ===== verif/vmt_pipe_model.sv
// Purpose: pipeline stand-in issuing virtual addresses
// Assumes: one request per call, launched after a rising edge
// Notes:   released address lines show the inverse, not the old value
`timescale 1ns/10ps
module vmt_pipe_model (
    input  wire logic         clock,
    output vmt_pkg::vmt_req_t req
);
    import vmt_pkg::*;
    initial req = '0;
    // hold for one edge, then drop valid and scramble the address
    task automatic issue(input logic [31:0] va, input logic w);
        @(posedge clock);
        req <= '{valid: 1'b1, isWrite: w, vaddr: va};
        @(posedge clock);
        req <= '{valid: 1'b0, isWrite: !w, vaddr: ~va};
    endtask : issue
endmodule : vmt_pipe_model

// ===== verif/vmt_xlate_props.sv
// Purpose: port-level checks of the translation block
// Assumes: one clock, asynchronous active low reset
// Notes:   bound into every vmt_xlate instance
`timescale 1ns/10ps
module vmt_xlate_props (
    input wire logic         clock,
    input wire logic         reset_n,
    input wire logic         avs_read,
    input wire logic         avs_write,
    input wire logic         avs_waitrequest,
    input vmt_pkg::vmt_req_t xlateReq,
    input wire logic         otherExcTaken,
    input vmt_pkg::vmt_rsp_t xlateRsp,
    input wire logic         kernelMode
);
    import vmt_pkg::*;
    default clocking cb @(posedge clock); endclocking
    default disable iff (!reset_n);
    // every request answered on the very next cycle
    chk_answer_next: assert property (xlateReq.valid
        |=> xlateRsp.done) else $error("no answer after request");
    // cached direct segment keeps the low 29 bits
    chk_cached_direct: assert property (xlateReq.valid
        && kernelMode
        && xlateReq.vaddr[31:29] == 3'b100 |=> xlateRsp.cached
        && xlateRsp.paddr == ($past(xlateReq.vaddr) & 32'h1FFF_FFFF))
        else $error("cached direct segment wrong");
    chk_uncached_direct: assert property (xlateReq.valid
        && kernelMode
        && xlateReq.vaddr[31:29] == 3'b101 |=> !xlateRsp.cached
        && xlateRsp.paddr == ($past(xlateReq.vaddr) & 32'h1FFF_FFFF))
        else $error("uncached direct segment wrong");
    chk_user_high: assert property (xlateReq.valid
        && !kernelMode
        && xlateReq.vaddr[31] |=> xlateRsp.fault == FLT_ADDR)
        else $error("user access to kernel half not refused");
    // page offset passes through on any good translation
    chk_page_offset: assert property (xlateReq.valid
        ##1 xlateRsp.fault == FLT_NONE |-> ((xlateRsp.paddr
        ^ $past(xlateReq.vaddr)) & 32'h0000_0FFF) == 32'h0000_0000)
        else $error("page offset altered");
    // no mode write is issued by the bench right after a fault
    chk_fault_kernel: assert property (xlateRsp.done
        && xlateRsp.fault != FLT_NONE && !avs_write |=> kernelMode)
        else $error("fault left user mode");
    chk_exc_kernel: assert property (otherExcTaken
        |=> kernelMode)
        else $error("exception left user mode");
    chk_ack_one: assert property ((avs_read || avs_write)
        && avs_waitrequest |=> !avs_waitrequest ##1 avs_waitrequest)
        else $error("register access not one wait state");
endmodule : vmt_xlate_props
bind vmt_xlate vmt_xlate_props vmt_xlate_props_inst (.clock(clock),
    .reset_n(reset_n), .avs_read(avs_read), .avs_write(avs_write),
    .avs_waitrequest(avs_waitrequest), .xlateReq(xlateReq),
    .otherExcTaken(otherExcTaken), .xlateRsp(xlateRsp),
    .kernelMode(kernelMode));

// ===== verilog/vmt_pkg.sv
// Purpose: shared constants and types of the address translation block
// Assumes: 32-bit addresses, 4 KiB pages, 64 translation entries
// Notes:   byte offsets of the Avalon register map live here
package vmt_pkg;

    // entry array geometry
    localparam int          ENTRIES   = 64;
    localparam int          IDX_W     = 6;
    localparam int          VPN_W     = 20;
    localparam int          TAG_W     = 6;
    localparam int          OFFS_W    = 12;

    // register byte offsets on the Avalon slave
    localparam logic [5:0]  OFS_UPPER = 6'h00;   // entry upper staging
    localparam logic [5:0]  OFS_LOWER = 6'h04;   // entry lower staging
    localparam logic [5:0]  OFS_INDEX = 6'h08;   // index pointer
    localparam logic [5:0]  OFS_RAND  = 6'h0C;   // random pointer, ro
    localparam logic [5:0]  OFS_CTX   = 6'h10;   // context pointer
    localparam logic [5:0]  OFS_FAULT = 6'h14;   // faulting vaddr, ro
    localparam logic [5:0]  OFS_REV   = 6'h18;   // revision ident, ro
    localparam logic [5:0]  OFS_MODE  = 6'h1C;   // current/previous mode
    localparam logic [5:0]  OFS_OP    = 6'h20;   // operation trigger, wo

    // field positions inside the registers
    localparam int          UP_VPN_LSB  = 12;
    localparam int          UP_TAG_LSB  = 6;
    localparam int          LO_PFN_LSB  = 12;
    localparam int          LO_NC_BIT   = 11;
    localparam int          LO_WE_BIT   = 10;
    localparam int          LO_VAL_BIT  = 9;
    localparam int          LO_GLB_BIT  = 8;
    localparam int          IX_FAIL_BIT = 31;
    localparam int          IX_LSB      = 8;
    localparam int          CTX_BASE_LSB = 21;
    localparam int          CTX_BVPN_LSB = 2;

    // reset values
    localparam logic [IDX_W-1:0] RAND_RST = 6'h3F;
    localparam logic [31:0]      REV_DFLT = 32'h0000_0001; // arbitrary

    // operation codes written to the trigger register
    typedef enum logic [2:0] {
        OP_NONE  = 3'h0,
        OP_RDIX  = 3'h1,   // xlate_read_indexed
        OP_WRIX  = 3'h2,   // xlate_write_indexed
        OP_WRRND = 3'h3,   // xlate_write_random
        OP_PROBE = 3'h4,   // xlate_probe
        OP_RFE   = 3'h5    // return_from_exception_op
    } vmt_op_t;

    // fault codes on the translation answer
    typedef enum logic [1:0] {
        FLT_NONE = 2'h0,
        FLT_ADDR = 2'h1,   // kernel-only address from user mode
        FLT_MISS = 2'h2,   // no entry, or entry not valid
        FLT_WPRT = 2'h3    // store to a page without write permission
    } vmt_fault_t;

    // one translation entry
    typedef struct packed {
        logic [VPN_W-1:0] virtual_page_number;
        logic [TAG_W-1:0] tag;
        logic [VPN_W-1:0] physical_frame_number;
        logic             nocache;
        logic             wrEn;
        logic             valid;
        logic             global;
    } vmt_entry_t;

    // translation request from the pipeline
    typedef struct packed {
        logic        valid;
        logic        isWrite;
        logic [31:0] vaddr;
    } vmt_req_t;

    // translation answer toward caches and memory
    typedef struct packed {
        logic        done;
        logic        cached;
        vmt_fault_t  fault;
        logic [31:0] paddr;
    } vmt_rsp_t;

endpackage : vmt_pkg

// ===== verilog/vmt_random_ptr.sv
// Purpose: free running replacement pointer over the entry array
// Assumes: one clock, asynchronous active low reset
// Notes:   steps down every cycle, so its value is effectively random
`timescale 1ns/10ps
module vmt_random_ptr (
    input  wire logic                      clock,
    input  wire logic                      reset_n,
    output logic [vmt_pkg::IDX_W-1:0]      ptr
);
    import vmt_pkg::*;

    logic [IDX_W-1:0] ptr_r;    // current pointer
    logic [IDX_W-1:0] ptr_nxt;  // next pointer

    // count down and wrap from zero to the top entry
    always_comb begin
        ptr_nxt = ptr_r - 6'h01;
    end

    // register only
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            ptr_r <= RAND_RST;
        end else begin
            ptr_r <= ptr_nxt;
        end
    end

    assign ptr = ptr_r;

endmodule : vmt_random_ptr

// ===== verilog/vmt_tag_match.sv
// Purpose: compare one entry against a translation key and a probe key
// Assumes: purely combinational, one instance per entry
// Notes:   the global flag drops the tag from the comparison
`timescale 1ns/10ps
module vmt_tag_match (
    input  vmt_pkg::vmt_entry_t              entry,
    input  wire logic [vmt_pkg::VPN_W-1:0]   xVpn,
    input  wire logic [vmt_pkg::TAG_W-1:0]   xTag,
    input  wire logic [vmt_pkg::VPN_W-1:0]   pVpn,
    input  wire logic [vmt_pkg::TAG_W-1:0]   pTag,
    output logic                             xHit,
    output logic                             pHit
);
    import vmt_pkg::*;

    // two ports so a probe never waits for a pipeline lookup
    always_comb begin
        xHit = (entry.virtual_page_number == xVpn) && (entry.global || entry.tag == xTag);
        pHit = (entry.virtual_page_number == pVpn) && (entry.global || entry.tag == pTag);
    end

endmodule : vmt_tag_match

// ===== verilog/vmt_xlate.sv
// Purpose: virtual to physical translation with software managed entries
// Assumes: Avalon-MM slave with one wait state; pipeline on same clock
// Notes:   translation answer is registered, one cycle after request
//
// Register access over Avalon-MM and the placing of the registers were chosen for this implementation.
`timescale 1ns/10ps
module vmt_xlate #(
    parameter logic [31:0] REVISION_IDENT = vmt_pkg::REV_DFLT // arbitrary
) (
    input  wire logic          clock,
    input  wire logic          reset_n,
    // Avalon-MM register slave
    input  wire logic [5:0]    avs_address,
    input  wire logic          avs_read,
    input  wire logic          avs_write,
    input  wire logic [31:0]   avs_writedata,
    input  wire logic [3:0]    avs_byteenable,
    output logic [31:0]        avs_readdata,
    output logic               avs_waitrequest,
    // pipeline side
    input  vmt_pkg::vmt_req_t  xlateReq,
    input  wire logic          otherExcTaken,
    // cache and memory side
    output vmt_pkg::vmt_rsp_t  xlateRsp,
    output logic               kernelMode
);
    import vmt_pkg::*;

    // merge a bus write into a register under byte enables
    function automatic logic [31:0] beMerge(input logic [31:0] old,
                                            input logic [31:0] wd,
                                            input logic [3:0]  be);
        logic [31:0] res;
        res = old;
        for (int b = 0; b < 4; b++) begin
            if (be[b]) begin
                res[b*8 +: 8] = wd[b*8 +: 8];
            end
        end
        return res;
    endfunction : beMerge

    // one-hot hit vector to entry position, lowest wins
    function automatic logic [IDX_W-1:0] hitIndex(
        input logic [ENTRIES-1:0] hv);
        logic [IDX_W-1:0] res;
        res = '0;
        for (int i = ENTRIES - 1; i >= 0; i--) begin
            if (hv[i]) begin
                res = IDX_W'(i);
            end
        end
        return res;
    endfunction : hitIndex

    // bus handshake states
    typedef enum logic [1:0] {
        BUS_IDLE = 2'b01,   // waitrequest high, looking for a request
        BUS_ACK  = 2'b10    // waitrequest low, access completes
    } vmt_bus_t;

    vmt_bus_t          busSt_r,  busSt_nxt;   // handshake state
    logic [31:0]       rdData_r, rdData_nxt;  // registered read data
    logic              waitReq_r, waitReq_nxt; // waitrequest flop

    // software visible state
    logic [31:0]       upper_r,  upper_nxt;   // entry upper staging
    logic [31:0]       lower_r,  lower_nxt;   // entry lower staging
    logic [IDX_W-1:0]  index_r,  index_nxt;   // index pointer
    logic              pFail_r,  pFail_nxt;   // probe failure flag
    logic [10:0]       ctxBase_r, ctxBase_nxt; // page table base
    logic [18:0]       badVpn_r, badVpn_nxt;  // page of last fault
    logic [31:0]       fault_r,  fault_nxt;   // faulting vaddr
    logic              curUser_r, curUser_nxt; // current mode, 1 = user
    logic              prvUser_r, prvUser_nxt; // previous mode

    // entry array and its next value
    vmt_entry_t        ent_r   [ENTRIES];
    vmt_entry_t        ent_nxt [ENTRIES];

    // translation answer
    vmt_rsp_t          rsp_r, rsp_nxt;

    // decode and lookup wires
    logic              wrTake;                // write takes effect now
    logic              rdTake;                // read request seen
    vmt_op_t           opCode;                // operation on this write
    logic [IDX_W-1:0]  randPtr;               // replacement pointer
    logic [ENTRIES-1:0] xHitV;                // lookup hits
    logic [ENTRIES-1:0] pHitV;                // probe hits
    vmt_entry_t        stageEnt;              // staging as an entry
    vmt_entry_t        xEnt;                  // entry that hit
    logic              ownFault;              // fault raised here

    vmt_random_ptr u_rand (
        .clock   (clock),
        .reset_n (reset_n),
        .ptr     (randPtr)
    );

    // one comparator pair per entry, all in parallel
    for (genvar g = 0; g < ENTRIES; g++) begin : g_match
        vmt_tag_match u_match (
            .entry (ent_r[g]),
            .xVpn  (xlateReq.vaddr[31:UP_VPN_LSB]),
            .xTag  (upper_r[UP_TAG_LSB +: TAG_W]),
            .pVpn  (upper_r[31:UP_VPN_LSB]),
            .pTag  (upper_r[UP_TAG_LSB +: TAG_W]),
            .xHit  (xHitV[g]),
            .pHit  (pHitV[g])
        );
    end

    // bus handshake: one wait state on every access
    always_comb begin
        busSt_nxt   = busSt_r;
        waitReq_nxt = 1'b1;
        case (busSt_r)
            BUS_IDLE: begin
                if (avs_read || avs_write) begin
                    busSt_nxt   = BUS_ACK;
                    waitReq_nxt = 1'b0;
                end
            end
            BUS_ACK: begin
                busSt_nxt = BUS_IDLE;
            end
            default: begin
                busSt_nxt = BUS_IDLE;
            end
        endcase
    end

    assign wrTake = (busSt_r == BUS_ACK) && avs_write;
    assign rdTake = (busSt_r == BUS_IDLE) && avs_read;
    // only a write with the low lane enabled starts an operation
    assign opCode = (wrTake && avs_address == OFS_OP && avs_byteenable[0])
                  ? vmt_op_t'(avs_writedata[2:0]) : OP_NONE;

    // staging halves seen as one entry
    always_comb begin
        stageEnt.virtual_page_number     = upper_r[31:UP_VPN_LSB];
        stageEnt.tag     = upper_r[UP_TAG_LSB +: TAG_W];
        stageEnt.physical_frame_number     = lower_r[31:LO_PFN_LSB];
        stageEnt.nocache = lower_r[LO_NC_BIT];
        stageEnt.wrEn    = lower_r[LO_WE_BIT];
        stageEnt.valid   = lower_r[LO_VAL_BIT];
        stageEnt.global  = lower_r[LO_GLB_BIT];
    end

    // read data is sampled while waitrequest is still high
    always_comb begin
        rdData_nxt = rdData_r;
        if (rdTake) begin
            if (avs_address == OFS_UPPER) begin
                rdData_nxt = upper_r;
            end else if (avs_address == OFS_LOWER) begin
                rdData_nxt = lower_r;
            end else if (avs_address == OFS_INDEX) begin
                rdData_nxt = '0;
                rdData_nxt[IX_FAIL_BIT] = pFail_r;
                rdData_nxt[IX_LSB +: IDX_W] = index_r;
            end else if (avs_address == OFS_RAND) begin
                rdData_nxt = '0;
                rdData_nxt[IX_LSB +: IDX_W] = randPtr;
            end else if (avs_address == OFS_CTX) begin
                rdData_nxt = {ctxBase_r, badVpn_r, 2'b00};
            end else if (avs_address == OFS_FAULT) begin
                rdData_nxt = fault_r;
            end else if (avs_address == OFS_REV) begin
                rdData_nxt = REVISION_IDENT;
            end else if (avs_address == OFS_MODE) begin
                rdData_nxt = {30'h0000_0000, prvUser_r, curUser_r};
            end else begin
                rdData_nxt = '0;        // unmapped and write-only read 0
            end
        end
    end

    // bus state registers
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            busSt_r   <= BUS_IDLE;
            waitReq_r <= 1'b1;
            rdData_r  <= '0;
        end else begin
            busSt_r   <= busSt_nxt;
            waitReq_r <= waitReq_nxt;
            rdData_r  <= rdData_nxt;
        end
    end

    // lookup of the pipeline request, answered next cycle
    always_comb begin
        rsp_nxt          = '0;
        xEnt             = ent_r[hitIndex(xHitV)];
        rsp_nxt.done     = xlateReq.valid;
        // low twelve bits always pass through
        rsp_nxt.paddr[OFFS_W-1:0] = xlateReq.vaddr[OFFS_W-1:0];
        if (xlateReq.vaddr[31] && curUser_r) begin
            rsp_nxt.fault = FLT_ADDR;
        end else if (xlateReq.vaddr[31:29] == 3'b100) begin
            // direct and cached, top three bits cleared
            rsp_nxt.paddr  = {3'b000, xlateReq.vaddr[28:0]};
            rsp_nxt.cached = 1'b1;
        end else if (xlateReq.vaddr[31:29] == 3'b101) begin
            // direct and uncached, same physical window
            rsp_nxt.paddr  = {3'b000, xlateReq.vaddr[28:0]};
            rsp_nxt.cached = 1'b0;
        end else begin
            // user segment in either mode, or top kernel segment
            if (xHitV == '0 || !xEnt.valid) begin
                rsp_nxt.fault = FLT_MISS;
            end else if (xlateReq.isWrite && !xEnt.wrEn) begin
                rsp_nxt.fault = FLT_WPRT;
            end else begin
                rsp_nxt.paddr[31:OFFS_W] = xEnt.physical_frame_number;
                rsp_nxt.cached = !xEnt.nocache;
            end
        end
        if (!xlateReq.valid) begin
            rsp_nxt = '0;       // idle answer keeps outputs quiet
        end
    end

    assign ownFault = rsp_nxt.done && (rsp_nxt.fault != FLT_NONE);

    // software state, operations, mode and fault capture
    always_comb begin
        upper_nxt   = upper_r;
        lower_nxt   = lower_r;
        index_nxt   = index_r;
        pFail_nxt   = pFail_r;
        ctxBase_nxt = ctxBase_r;
        badVpn_nxt  = badVpn_r;
        fault_nxt   = fault_r;
        curUser_nxt = curUser_r;
        prvUser_nxt = prvUser_r;
        // plain register writes
        if (wrTake) begin
            if (avs_address == OFS_UPPER) begin
                upper_nxt = beMerge(upper_r, avs_writedata,
                                    avs_byteenable);
            end else if (avs_address == OFS_LOWER) begin
                lower_nxt = beMerge(lower_r, avs_writedata,
                                    avs_byteenable);
            end else if (avs_address == OFS_INDEX) begin
                if (avs_byteenable[1]) begin
                    index_nxt = avs_writedata[IX_LSB +: IDX_W];
                end
                if (avs_byteenable[3]) begin
                    pFail_nxt = avs_writedata[IX_FAIL_BIT];
                end
            end else if (avs_address == OFS_CTX) begin
                // only the base is software owned, lanes 2 and 3
                if (avs_byteenable[3]) begin
                    ctxBase_nxt[10:3] = avs_writedata[31:24];
                end
                if (avs_byteenable[2]) begin
                    ctxBase_nxt[2:0] = avs_writedata[23:CTX_BASE_LSB];
                end
            end else if (avs_address == OFS_MODE) begin
                if (avs_byteenable[0]) begin
                    curUser_nxt = avs_writedata[0];
                    prvUser_nxt = avs_writedata[1];
                end
            end
            // revision, random, fault and unmapped writes are dropped
        end
        // indexed read fills the staging pair
        if (opCode == OP_RDIX) begin
            upper_nxt = '0;
            lower_nxt = '0;
            upper_nxt[31:UP_VPN_LSB]        = ent_r[index_r].virtual_page_number;
            upper_nxt[UP_TAG_LSB +: TAG_W]  = ent_r[index_r].tag;
            lower_nxt[31:LO_PFN_LSB]        = ent_r[index_r].physical_frame_number;
            lower_nxt[LO_NC_BIT]            = ent_r[index_r].nocache;
            lower_nxt[LO_WE_BIT]            = ent_r[index_r].wrEn;
            lower_nxt[LO_VAL_BIT]           = ent_r[index_r].valid;
            lower_nxt[LO_GLB_BIT]           = ent_r[index_r].global;
        end
        // probe reports the match position or failure
        if (opCode == OP_PROBE) begin
            if (pHitV == '0) begin
                pFail_nxt = 1'b1;
            end else begin
                pFail_nxt = 1'b0;
                index_nxt = hitIndex(pHitV);
            end
        end
        // return op restores the previous mode
        if (opCode == OP_RFE) begin
            curUser_nxt = prvUser_r;
        end
        // an exception outranks a same-cycle return or mode write
        if (ownFault || otherExcTaken) begin
            prvUser_nxt = curUser_r;
            curUser_nxt = 1'b0;
        end
        // capture address of an address or translation fault
        if (ownFault) begin
            fault_nxt  = xlateReq.vaddr;
            badVpn_nxt = xlateReq.vaddr[30:UP_VPN_LSB];
        end
    end

    // entry array writes: indexed or random victim
    always_comb begin
        for (int i = 0; i < ENTRIES; i++) begin
            ent_nxt[i] = ent_r[i];
        end
        if (opCode == OP_WRIX) begin
            ent_nxt[index_r] = stageEnt;
        end else if (opCode == OP_WRRND) begin
            ent_nxt[randPtr] = stageEnt;
        end
    end

    // register only: software state
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            upper_r   <= '0;
            lower_r   <= '0;
            index_r   <= '0;
            pFail_r   <= 1'b0;
            ctxBase_r <= '0;
            badVpn_r  <= '0;
            fault_r   <= '0;
            curUser_r <= 1'b0;      // reset starts in kernel mode
            prvUser_r <= 1'b0;
        end else begin
            upper_r   <= upper_nxt;
            lower_r   <= lower_nxt;
            index_r   <= index_nxt;
            pFail_r   <= pFail_nxt;
            ctxBase_r <= ctxBase_nxt;
            badVpn_r  <= badVpn_nxt;
            fault_r   <= fault_nxt;
            curUser_r <= curUser_nxt;
            prvUser_r <= prvUser_nxt;
        end
    end

    // register only: entry array and answer
    // clearing at reset costs area but removes stale hits
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            for (int i = 0; i < ENTRIES; i++) begin
                ent_r[i] <= '0;
            end
            rsp_r <= '0;
        end else begin
            for (int i = 0; i < ENTRIES; i++) begin
                ent_r[i] <= ent_nxt[i];
            end
            rsp_r <= rsp_nxt;
        end
    end

    // outputs straight from flops
    assign avs_readdata    = rdData_r;
    assign avs_waitrequest = waitReq_r;
    assign xlateRsp        = rsp_r;
    assign kernelMode      = !curUser_r;

endmodule : vmt_xlate
